//--- pkg/pwmt_pkg.sv
package pwmt_pkg;
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_CMD  = 6'h01;
  localparam logic [5:0] IDX_CMPB = 6'h03;
  localparam logic [5:0] IDX_EVA  = 6'h08;
  localparam logic [5:0] IDX_EVB  = 6'h09;
  localparam logic [5:0] IDX_IEN  = 6'h0C;
  localparam logic [5:0] IDX_IFL  = 6'h0D;
  localparam logic [5:0] IDX_STS  = 6'h0E;
  localparam logic [5:0] IDX_ICLR = 6'h1C;
  // event control fields
  localparam int CFG_HI = 7;
  localparam int CFG_LO = 6;
  localparam int POL_B  = 4;
  localparam int ACT_B  = 2;
  localparam int TEN_B  = 0;
  localparam logic [1:0] CFG_FILT  = 2'h1;
  localparam logic [1:0] CFG_ASYNC = 2'h2;
  // flag, enable and status bits
  localparam int FL_TB   = 3;
  localparam int FL_TA   = 2;
  localparam int FL_OVF  = 0;
  localparam int ST_ACTB = 7;
  localparam int ST_ACTA = 6;
  localparam int ST_CMD  = 1;
  localparam int ST_EN   = 0;
  localparam logic [7:0] IRQ_MASK = 8'h0D;
  localparam logic [7:0] ACT_MASK = 8'hC0;
  // own control and command bits
  localparam int CT_EN   = 0;
  localparam int CT_AUTO = 1;
  localparam int CT_DRUN = 2;
  localparam logic [7:0] CTRL_MASK = 8'h07;
  localparam logic [4:0] CMD_MASK = 5'h1F;
  localparam int CM_STOP = 7;
  // filter and domain sync timing
  localparam int FILT_LEN = 4;
  localparam logic [FILT_LEN-1:0] FILT_ONES = 4'hF;
  localparam logic [FILT_LEN-1:0] FILT_ZERO = 4'h0;
  localparam int CLK_NS  = 50;
  localparam int SYNC_NS = 150;
  localparam int SYNC_CYC = (SYNC_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 2;
  localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : pwmt_pkg

//--- sim/pwmt_core_model.sv
`timescale 1ns/1ps
// stand-in for the counter core: one cycle end every PER clocks while running
module pwmt_core_model #(
  parameter int PER = 8
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic timer_enable,
  input  wire logic go,
  output logic      cycle_end,
  output logic      wo_a,
  output logic      wo_b
);
  logic [7:0] cnt_r;
  logic       wrap;

  assign wrap = (cnt_r == 8'(PER - 1));

  // go lets the bench hold the cycle end back, as a long timer period would
  always_ff @(posedge clk) begin
    if (reset || !timer_enable || !go) begin
      cnt_r     <= 8'h00;
      cycle_end <= 1'b0;
    end else begin
      cnt_r     <= wrap ? 8'h00 : cnt_r + 8'h01;
      cycle_end <= wrap;
    end
  end

  // both outputs toggle at each cycle end so activity shows on each
  always_ff @(posedge clk) begin
    if (reset) begin
      wo_a <= 1'b0;
      wo_b <= 1'b0;
    end else if (cycle_end) begin
      wo_a <= ~wo_a;
      wo_b <= ~wo_b;
    end
  end
endmodule : pwmt_core_model

//--- sim/pwmt_event_status_tb.sv
`timescale 1ns/1ps
module pwmt_event_status_tb
  import pwmt_pkg::*;
;
  logic clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, event_a_in, event_b_in, debug_break, go;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic waveform_output_a, waveform_output_b, cycle_end, fault_a, fault_b;
  logic capture_a, capture_b, fault_a_async, fault_b_async, cmd_eoc_load;
  logic cmd_imm_load, cmd_restart, cmd_grab_a, cmd_grab_b, timer_enable, irq;
  logic [6:0]  pv;
  int          pc [7];
  int          base [7];
  int          bad_count, tests_run, cyc;

  pwmt_event_status dut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .event_a_in, .event_b_in, .waveform_output_a, .waveform_output_b,
    .cycle_end, .debug_break, .fault_a, .fault_b, .capture_a, .capture_b,
    .fault_a_async, .fault_b_async, .cmd_eoc_load, .cmd_imm_load,
    .cmd_restart, .cmd_grab_a, .cmd_grab_b, .timer_enable, .irq);
  pwmt_core_model core (.clk, .reset, .timer_enable, .go, .cycle_end,
    .wo_a(waveform_output_a), .wo_b(waveform_output_b));

  // pulse counters; scenarios compare against a snapshot, never a reset
  assign pv = {capture_b, capture_a, cmd_grab_b, cmd_grab_a, cmd_restart,
               cmd_imm_load, cmd_eoc_load};
  always @(posedge clk) begin
    for (int i = 0; i < 7; i++) pc[i] += (pv[i] === 1'b1);
  end

  // a hang counts as a mismatch and still reaches the report
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk

  // write address and data offered together, each dropped once taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                    input logic [1:0] er = RESP_OK);
    bit done;
    done = 0;
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        done = 1;
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(s_axi_bresp));
      end
    end
  endtask : wr

  task automatic rd(input logic [5:0] idx, output logic [31:0] d,
                    output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge clk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        done = 1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask : rd

  task automatic rchk(input logic [5:0] idx, input logic [7:0] m, e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    chk($sformatf("reg %h", idx), 32'(e), d & 32'(m));
  endtask : rchk

  task automatic wt(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wt

  // software polls the ready bit before the next command or enable write
  task automatic wait_rdy(input int b);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    d = 32'h0;
    n = 0;
    while (d[b] !== 1'b1 && n < 20) begin
      rd(IDX_STS, d, r);
      n++;
    end
    chk("ready", 32'h1, 32'(d[b]));
  endtask : wait_rdy

  task automatic t_regs();
    logic [5:0]  zi [4] = '{IDX_EVA, IDX_EVB, IDX_IEN, IDX_IFL};
    logic [31:0] d;
    logic [1:0]  r;
    foreach (zi[i]) rchk(zi[i], 8'hFF, 8'h00);
    rchk(IDX_STS, 8'hFF, 8'h03);
    rd(6'h20, d, r);
    chk("rresp", 32'(RESP_ERR), 32'(r));
    wr(6'h20, 8'h5A, RESP_ERR);
  endtask : t_regs

  task automatic t_trig_a();
    wr(IDX_IEN, 8'h04);
    wr(IDX_EVA, 8'h15);
    base = pc;
    @(posedge clk);
    event_a_in <= 1'b1;
    wt(irq, 1'b1, 20);
    chk("irq", 32'h1, 32'(irq));
    chk("fault_a", 32'h1, 32'(fault_a));
    chk("fault_a_async", 32'h0, 32'(fault_a_async));
    chk("capture_a", 32'h1, 32'(pc[5] - base[5]));
    rchk(IDX_IFL, 8'h0D, 8'h04);
    wr(IDX_IEN, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, 32'(irq));
    event_a_in <= 1'b0;
    repeat (10) @(posedge clk);
    wr(IDX_IFL, 8'h04);
    rchk(IDX_IFL, 8'h0D, 8'h00);
    wr(IDX_EVA, 8'h14);
    base = pc;
    event_a_in <= 1'b1;
    repeat (10) @(posedge clk);
    chk("fault_a off", 32'h0, 32'(fault_a));
    chk("capture off", 32'h0, 32'(pc[5] - base[5]));
    event_a_in <= 1'b0;
  endtask : t_trig_a

  task automatic lat(input logic [7:0] cfg, output int n);
    wr(IDX_EVB, cfg);
    repeat (10) @(posedge clk);
    event_b_in <= 1'b1;
    n = 0;
    while (fault_b !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    event_b_in <= 1'b0;
    repeat (20) @(posedge clk);
  endtask : lat

  task automatic t_evt_b();
    int  d0, d1;
    bit  seen;
    base = pc;
    lat(8'h11, d0);
    lat(8'h51, d1);
    chk("filter delay", 32'h4, 32'(d1 - d0));
    chk("capture_b none", 32'h0, 32'(pc[6] - base[6]));
    rchk(IDX_IFL, 8'h0D, 8'h08);
    wr(IDX_IFL, 8'h08);
    rchk(IDX_IFL, 8'h0D, 8'h00);
    seen = 0;
    event_b_in <= 1'b1;
    repeat (3) @(posedge clk);
    event_b_in <= 1'b0;
    repeat (15) begin
      @(posedge clk);
      seen |= (fault_b === 1'b1);
    end
    chk("glitch", 32'h0, 32'(seen));
    wr(IDX_EVB, 8'h01);
    repeat (10) @(posedge clk);
    chk("low active", 32'h1, 32'(fault_b));
    event_b_in <= 1'b1;
    repeat (10) @(posedge clk);
    chk("low idle", 32'h0, 32'(fault_b));
    event_b_in <= 1'b0;
    wr(IDX_EVB, 8'h91);
    event_b_in <= 1'b1;
    @(negedge clk);
    chk("async hi", 32'h1, 32'(fault_b_async));
    @(posedge clk);
    event_b_in <= 1'b0;
    @(negedge clk);
    chk("async lo", 32'h0, 32'(fault_b_async));
    wr(IDX_EVB, 8'h00);
  endtask : t_evt_b

  task automatic t_run();
    go <= 1'b1;
    wr(IDX_CTRL, 8'h01);
    wt(timer_enable, 1'b1, 20);
    chk("enable", 32'h1, 32'(timer_enable));
    wait_rdy(ST_EN);
    wr(IDX_IEN, 8'h01);
    wt(irq, 1'b1, 40);
    chk("irq cycle end", 32'h1, 32'(irq));
    rchk(IDX_STS, ACT_MASK, 8'hC0);
    go <= 1'b0;
    wr(IDX_STS, 8'hC0);
    rchk(IDX_STS, ACT_MASK, 8'h00);
    wr(IDX_ICLR, 8'h0D);
    rchk(IDX_IFL, 8'h0D, 8'h00);
    chk("irq clear", 32'h0, 32'(irq));
    for (int i = 0; i < 5; i++) begin
      wait_rdy(ST_CMD);
      base = pc;
      wr(IDX_CMD, 8'(1 << i));
      repeat (10) @(posedge clk);
      chk($sformatf("cmd %0d", i), 32'h1, 32'(pc[i] - base[i]));
    end
    wr(IDX_CTRL, 8'h03);
    base = pc;
    wr(IDX_CMPB, 8'h12);
    repeat (10) @(posedge clk);
    chk("auto load", 32'h1, 32'(pc[0] - base[0]));
    wait_rdy(ST_CMD);
    wr(IDX_CMD, 8'h80);
    rchk(IDX_STS, 8'h01, 8'h00);
    wr(IDX_CTRL, 8'h00);
    rchk(IDX_CTRL, 8'h01, 8'h01);
    go <= 1'b1;
    wt(timer_enable, 1'b0, 60);
    chk("stop", 32'h0, 32'(timer_enable));
    wait_rdy(ST_EN);
    wr(IDX_CTRL, 8'h01);
    wt(timer_enable, 1'b1, 20);
    debug_break <= 1'b1;
    wt(timer_enable, 1'b0, 10);
    chk("debug halt", 32'h0, 32'(timer_enable));
    debug_break <= 1'b0;
    wt(timer_enable, 1'b1, 10);
    chk("debug resume", 32'h1, 32'(timer_enable));
    wait_rdy(ST_EN);
    wr(IDX_CTRL, 8'h05);
    debug_break <= 1'b1;
    repeat (10) @(posedge clk);
    chk("debug run", 32'h1, 32'(timer_enable));
    debug_break <= 1'b0;
  endtask : t_run

  initial begin
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, go} = 3'h0;
    {event_a_in, event_b_in, debug_break} = 3'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_trig_a();
    t_evt_b();
    t_run();
    final_report();
  end
endmodule : pwmt_event_status_tb

//--- src/pwmt_event_status.sv
// What this block does
// - filtered event changes only after four equal consecutive samples.
// - filter adds exactly four clock cycles of delay to the event path.
// - async qualification drives the async fault output straight from the pin.
// - config field 7:6: 0 none, 1 filter, 2 async, others reserved.
// - bit 4 picks polarity: 0 falling or low, 1 rising or high.
// - bit 2: 0 fault only, 1 fault plus capture.
// - bit 0 enables the event as trigger for input A or B.
// - interrupt enables: bit 3 trigger B, bit 2 trigger A, bit 0 cycle end.
// - trigger B flag bit 3 set on trigger B, cleared by writing one.
// - trigger A flag bit 2 set on trigger A, cleared by writing one.
// - cycle end flag bit 0 set every cycle end, write one clears.
// - status bit 7 set on any output B toggle, write one clears.
// - status bit 6 set on any output A toggle, write one clears.
// - command ready drops on any command strobe, returns once synced.
// - enable ready drops on enable, stop, debug halt or release; rises when synced, or for a stop at the next cycle end, or on the next clock if the timer is off.
// - command strobes while a command is syncing are ignored.
// - enable writes while enable is syncing are ignored.
`timescale 1ns/1ps
module pwmt_event_status
  import pwmt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        event_a_in,
  input  wire logic        event_b_in,
  input  wire logic        waveform_output_a,
  input  wire logic        waveform_output_b,
  input  wire logic        cycle_end,
  input  wire logic        debug_break,
  output logic             fault_a,
  output logic             fault_b,
  output logic             capture_a,
  output logic             capture_b,
  output logic             fault_a_async,
  output logic             fault_b_async,
  output logic             cmd_eoc_load,
  output logic             cmd_imm_load,
  output logic             cmd_restart,
  output logic             cmd_grab_a,
  output logic             cmd_grab_b,
  output logic             timer_enable,
  output logic             irq
);

  function automatic logic is_idx(input logic [7:0] a,
                                  input logic [5:0] idx);
    is_idx = (a[7:2] == idx);
  endfunction : is_idx

  // register state
  logic [7:0] evctl_r [2];
  logic [7:0] ctrl_r, ien_r, fl_r, act_r, cmpb_r;
  logic [CNT_W-1:0] cmd_cnt_r, en_cnt_r;
  logic [4:0] cmd_pend_r;
  logic stop_pend_r, halt_prev_r;
  logic [7:0] rd_val;
  logic       map_r;

  // axi write channel state
  logic aw_held_r, w_held_r;
  logic [7:0] aw_addr_r, wd_r;
  logic wl0_r;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_held_r & w_held_r;
  wire aw_held_nxt = aw_take | (aw_held_r & ~wr_fire);
  wire w_held_nxt  = w_take | (w_held_r & ~wr_fire);
  wire bvalid_nxt  = wr_fire | (s_axi_bvalid & ~s_axi_bready);
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rvalid_nxt  = ar_take | (s_axi_rvalid & ~s_axi_rready);

  // address decode of the held write, byte lane 0 carries the data
  wire wr0   = wr_fire & wl0_r;
  wire wr_ct = wr0 & is_idx(aw_addr_r, IDX_CTRL);
  wire wr_cm = wr0 & is_idx(aw_addr_r, IDX_CMD);
  wire wr_cb = wr0 & is_idx(aw_addr_r, IDX_CMPB);
  wire wr_ea = wr0 & is_idx(aw_addr_r, IDX_EVA);
  wire wr_eb = wr0 & is_idx(aw_addr_r, IDX_EVB);
  wire wr_ie = wr0 & is_idx(aw_addr_r, IDX_IEN);
  wire wr_fl = wr0 & (is_idx(aw_addr_r, IDX_IFL) |
                      is_idx(aw_addr_r, IDX_ICLR));
  wire wr_st = wr0 & is_idx(aw_addr_r, IDX_STS);
  wire map_w = is_idx(aw_addr_r, IDX_CTRL) | is_idx(aw_addr_r, IDX_CMD) |
               is_idx(aw_addr_r, IDX_CMPB) | is_idx(aw_addr_r, IDX_EVA) |
               is_idx(aw_addr_r, IDX_EVB)  | is_idx(aw_addr_r, IDX_IEN) |
               is_idx(aw_addr_r, IDX_IFL)  | is_idx(aw_addr_r, IDX_ICLR) |
               is_idx(aw_addr_r, IDX_STS);

  // axi handshakes; one write and one read in flight at most
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OK;
      s_axi_rdata   <= '0;
    end else begin
      aw_held_r     <= aw_held_nxt;
      w_held_r      <= w_held_nxt;
      s_axi_awready <= ~aw_held_nxt & ~bvalid_nxt;
      s_axi_wready  <= ~w_held_nxt & ~bvalid_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      if (wr_fire)
        s_axi_bresp <= map_w ? RESP_OK : RESP_ERR;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_arready <= ~rvalid_nxt;
      if (ar_take) begin
        s_axi_rdata <= {24'h000000, rd_val};
        s_axi_rresp <= map_r ? RESP_OK : RESP_ERR;
      end
    end
  end

  // write payload is latched on its own handshake, no reset needed
  always_ff @(posedge clk) begin
    if (aw_take)
      aw_addr_r <= s_axi_awaddr;
    if (w_take) begin
      wd_r  <= s_axi_wdata[7:0];
      wl0_r <= s_axi_wstrb[0];
    end
  end

  // event inputs: two-stage sync, optional filter, polarity, edge
  wire [1:0] ev_pin = {event_b_in, event_a_in};
  logic ev_m_r [2];
  logic ev_s_r [2];
  logic [FILT_LEN-1:0] hist_r [2];
  logic filt_r [2];
  logic act_prev_r [2];
  logic fault_r [2];
  logic cap_r [2];
  logic filt_on [2];
  logic trig_hit [2];
  logic async_hit [2];

  for (genvar i = 0; i < 2; i++) begin : g_ev
    wire [1:0] cfg = evctl_r[i][CFG_HI:CFG_LO];
    wire lvl = filt_on[i] ? filt_r[i] : hist_r[i][0];
    wire act = evctl_r[i][POL_B] ? lvl : ~lvl;
    wire ten = evctl_r[i][TEN_B];
    wire hit = ten & act & ~act_prev_r[i];
    // reserved config codes behave as neither option
    assign filt_on[i]  = (cfg == CFG_FILT);
    assign trig_hit[i] = hit;
    // combinational on purpose: async qualification skips the clock
    assign async_hit[i] = ten & (cfg == CFG_ASYNC) &
                          (ev_pin[i] == evctl_r[i][POL_B]);

    always_ff @(posedge clk) begin
      if (reset) begin
        ev_m_r[i]     <= 1'b0;
        ev_s_r[i]     <= 1'b0;
        hist_r[i]     <= FILT_ZERO;
        filt_r[i]     <= 1'b0;
        act_prev_r[i] <= 1'b0;
        fault_r[i]    <= 1'b0;
        cap_r[i]      <= 1'b0;
      end else begin
        ev_m_r[i]     <= ev_pin[i];
        ev_s_r[i]     <= ev_m_r[i];
        hist_r[i]     <= {hist_r[i][FILT_LEN-2:0], ev_s_r[i]};
        if (hist_r[i] == FILT_ONES || hist_r[i] == FILT_ZERO)
          filt_r[i] <= hist_r[i][FILT_LEN-1];
        act_prev_r[i] <= act;
        fault_r[i]    <= ten & act;
        cap_r[i]      <= hit & evctl_r[i][ACT_B];
      end
    end
  end

  assign fault_a       = fault_r[0];
  assign fault_b       = fault_r[1];
  assign capture_a     = cap_r[0];
  assign capture_b     = cap_r[1];
  assign fault_a_async = async_hit[0];
  assign fault_b_async = async_hit[1];

  // flag set terms; a set in the clear cycle wins
  logic [7:0] fl_set, act_set;
  logic wo_a_prev_r, wo_b_prev_r;
  always_comb begin
    fl_set          = '0;
    fl_set[FL_TB]   = trig_hit[1];
    fl_set[FL_TA]   = trig_hit[0];
    fl_set[FL_OVF]  = cycle_end;
    act_set         = '0;
    act_set[ST_ACTB] = waveform_output_b ^ wo_b_prev_r;
    act_set[ST_ACTA] = waveform_output_a ^ wo_a_prev_r;
  end
  wire [7:0] fl_clr  = wr_fl ? wd_r : 8'h00;
  wire [7:0] act_clr = wr_st ? wd_r : 8'h00;
  wire [7:0] fl_nxt  = ((fl_r & ~fl_clr) | fl_set) & IRQ_MASK;
  wire [7:0] act_nxt = ((act_r & ~act_clr) | act_set) & ACT_MASK;
  wire       irq_src = |(fl_r & ien_r);

  // command sync: strobes pass to the timer side after SYNC_CYC
  wire cmd_rdy  = (cmd_cnt_r == CNT_ZERO);
  wire en_rdy   = (en_cnt_r == CNT_ZERO) & ~stop_pend_r;
  wire auto_ld  = wr_cb & ctrl_r[CT_AUTO];
  wire [4:0] cmd_req = (wr_cm ? (wd_r[4:0] & CMD_MASK) : 5'h00) |
                       {4'h0, auto_ld};
  wire cmd_go   = cmd_rdy & (cmd_req != 5'h00);
  wire cmd_fire = (cmd_cnt_r == CNT_ONE);
  wire halt     = debug_break & ~ctrl_r[CT_DRUN];
  wire en_wr_go = wr_ct & en_rdy;
  wire stop_go  = wr_cm & wd_r[CM_STOP] & en_rdy;
  wire en_go    = en_wr_go | (halt != halt_prev_r);

  // flags, status, config and the interrupt line
  always_ff @(posedge clk) begin
    if (reset) begin
      evctl_r[0]  <= 8'h00;
      evctl_r[1]  <= 8'h00;
      ien_r       <= 8'h00;
      fl_r        <= 8'h00;
      act_r       <= 8'h00;
      cmpb_r      <= 8'h00;
      wo_a_prev_r <= 1'b0;
      wo_b_prev_r <= 1'b0;
      irq         <= 1'b0;
    end else begin
      if (wr_ea) evctl_r[0] <= wd_r;
      if (wr_eb) evctl_r[1] <= wd_r;
      if (wr_ie) ien_r <= wd_r & IRQ_MASK;
      if (wr_cb) cmpb_r <= wd_r;
      fl_r        <= fl_nxt;
      act_r       <= act_nxt;
      wo_a_prev_r <= waveform_output_a;
      wo_b_prev_r <= waveform_output_b;
      irq         <= irq_src;
    end
  end

  // command and enable synchronisation toward the counter core
  always_ff @(posedge clk) begin
    if (reset) begin
      // both ready bits read low out of reset, then rise after one sync
      cmd_cnt_r    <= CNT_W'(SYNC_CYC);
      cmd_pend_r   <= 5'h00;
      en_cnt_r     <= CNT_W'(SYNC_CYC);
      ctrl_r       <= 8'h00;
      stop_pend_r  <= 1'b0;
      halt_prev_r  <= 1'b0;
      timer_enable <= 1'b0;
      {cmd_grab_b, cmd_grab_a, cmd_restart} <= 3'h0;
      {cmd_imm_load, cmd_eoc_load}          <= 2'h0;
    end else begin
      halt_prev_r <= halt;
      if (cmd_go) begin
        cmd_cnt_r  <= CNT_W'(SYNC_CYC);
        cmd_pend_r <= cmd_req;
      end else if (!cmd_rdy)
        cmd_cnt_r <= cmd_cnt_r - CNT_ONE;
      {cmd_grab_b, cmd_grab_a, cmd_restart, cmd_imm_load,
       cmd_eoc_load} <= cmd_fire ? cmd_pend_r : 5'h00;
      if (wr_ct)
        ctrl_r <= (wd_r & CTRL_MASK & ~(8'h01 << CT_EN)) |
                  (en_rdy ? (wd_r & 8'h01 << CT_EN)
                          : (ctrl_r & 8'h01 << CT_EN));
      if (en_go)
        en_cnt_r <= CNT_W'(SYNC_CYC);
      else if (en_cnt_r != CNT_ZERO)
        en_cnt_r <= en_cnt_r - CNT_ONE;
      if (en_cnt_r == CNT_ONE)
        timer_enable <= ctrl_r[CT_EN] & ~halt;
      if (stop_go)
        stop_pend_r <= 1'b1;
      else if (stop_pend_r & (cycle_end | ~timer_enable)) begin
        stop_pend_r       <= 1'b0;
        timer_enable      <= 1'b0;
        ctrl_r[CT_EN]     <= 1'b0;
      end
    end
  end

  // read data mux; strobe and clear registers read as zero
  logic [7:0] sts_val;
  always_comb begin
    sts_val         = act_r;
    sts_val[ST_CMD] = cmd_rdy;
    sts_val[ST_EN]  = en_rdy;
  end
  assign rd_val =
    is_idx(s_axi_araddr, IDX_CTRL) ? ctrl_r :
    is_idx(s_axi_araddr, IDX_CMPB) ? cmpb_r :
    is_idx(s_axi_araddr, IDX_EVA)  ? evctl_r[0] :
    is_idx(s_axi_araddr, IDX_EVB)  ? evctl_r[1] :
    is_idx(s_axi_araddr, IDX_IEN)  ? ien_r :
    is_idx(s_axi_araddr, IDX_IFL)  ? fl_r :
    is_idx(s_axi_araddr, IDX_STS)  ? sts_val : 8'h00;
  assign map_r = (rd_val != 8'h00) | is_idx(s_axi_araddr, IDX_CMD) |
    is_idx(s_axi_araddr, IDX_ICLR) | is_idx(s_axi_araddr, IDX_CTRL) |
    is_idx(s_axi_araddr, IDX_CMPB) | is_idx(s_axi_araddr, IDX_EVA) |
    is_idx(s_axi_araddr, IDX_EVB)  | is_idx(s_axi_araddr, IDX_IEN) |
    is_idx(s_axi_araddr, IDX_IFL)  | is_idx(s_axi_araddr, IDX_STS);

  // checks
  filter_agree_a: assert property (@(posedge clk) disable iff (reset)
    $changed(filt_r[0]) |->
      ($past(hist_r[0]) == FILT_ONES || $past(hist_r[0]) == FILT_ZERO))
    else $error("filter moved without four equal samples");
  filter_delay_a: assert property (@(posedge clk) disable iff (reset)
    (filt_on[0] && hist_r[0] == FILT_ONES && !filt_r[0]) |=> filt_r[0])
    else $error("filter output late");
  async_path_a: assert property (@(posedge clk) disable iff (reset)
    (evctl_r[0][CFG_HI:CFG_LO] == CFG_ASYNC && evctl_r[0][TEN_B] &&
     event_a_in == evctl_r[0][POL_B]) |-> fault_a_async)
    else $error("async fault missing");
  trig_flag_a: assert property (@(posedge clk) disable iff (reset)
    trig_hit[0] |=> fl_r[FL_TA])
    else $error("trigger A flag not set");
  ovf_flag_a: assert property (@(posedge clk) disable iff (reset)
    cycle_end |=> fl_r[FL_OVF])
    else $error("cycle end flag not set");
  act_b_set_a: assert property (@(posedge clk) disable iff (reset)
    $changed(waveform_output_b) |=> act_r[ST_ACTB])
    else $error("output B activity missed");
  cmd_ready_a: assert property (@(posedge clk) disable iff (reset)
    cmd_go |=> !cmd_rdy [*3] ##1 cmd_rdy)
    else $error("command ready timing wrong");
  cmd_ignore_a: assert property (@(posedge clk) disable iff (reset)
    (wr_cm && !cmd_rdy) |=> $stable(cmd_pend_r))
    else $error("command taken while busy");
  en_ready_a: assert property (@(posedge clk) disable iff (reset)
    en_wr_go |=> !en_rdy ##3 en_rdy || stop_pend_r)
    else $error("enable ready timing wrong");
  irq_level_a: assert property (@(posedge clk) disable iff (reset)
    ##1 irq == $past(irq_src))
    else $error("irq does not follow flags");

endmodule : pwmt_event_status
